// ===== hw/prs_params.svh
// Register map, field positions, masks and reset values of the picture resizer configuration
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH

// ------------------------------------------------------------
// Offsets
// ------------------------------------------------------------
`define PRS_OFF_MODE 8'h00
`define PRS_OFF_ROW_STEP 8'h04
`define PRS_OFF_VOFF_TOP 8'h08
`define PRS_OFF_VOFF_BOT 8'h0C
`define PRS_OFF_TARGET 8'h10
`define PRS_OFF_SOURCE 8'h14
`define PRS_OFF_AVG_INIT 8'h18
`define PRS_OFF_STRIP 8'h20
`define PRS_OFF_STATUS 8'h40

// ------------------------------------------------------------
// Writable bit masks and reset values
// ------------------------------------------------------------
`define PRS_MASK_MODE 32'h0000041F
`define PRS_MASK_ROW_STEP 32'h07FFFFFF
`define PRS_MASK_VOFF 32'h0FFFFFFF
`define PRS_MASK_TARGET 32'h777FF7FF
`define PRS_MASK_SOURCE 32'h077FF7FF
`define PRS_MASK_AVG_INIT 32'h000FFFFF
`define PRS_MASK_STRIP 32'h007FF000
`define PRS_RESET_VAL 32'h00000000

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PRS_BIT_OUT_ILACE 0
`define PRS_BIT_LINEAR 1
`define PRS_BIT_BYPASS 2
`define PRS_BIT_INVERT 3
`define PRS_BIT_AVG_SEL 4
`define PRS_BIT_IN_ILACE 10
`define PRS_W_LSB 12
`define PRS_W_MSB 22
`define PRS_H_LSB 0
`define PRS_H_MSB 10
`define PRS_UPPER_A_LSB 28
`define PRS_UPPER_A_MSB 30
`define PRS_UPPER_B_LSB 24
`define PRS_UPPER_B_MSB 26
`define PRS_INIT_TOP_LSB 0
`define PRS_INIT_TOP_MSB 9
`define PRS_INIT_BOT_LSB 10
`define PRS_INIT_BOT_MSB 19

`endif

// ===== hw/prs_pkg.sv
// Types shared by the picture resizer configuration block
package prs_pkg;
	typedef enum logic [1:0] {
		PRS_FIELD_FRAME,
		PRS_FIELD_TOP,
		PRS_FIELD_BOTTOM
	} prs_field_kind_t;
endpackage : prs_pkg

// ===== hw/prs_resizer_config.sv
// Picture resizer configuration registers and per-field setting selection
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "prs_params.svh"

module prs_resizer_config #(
	parameter int ADDR_W = 8,
	parameter int CNT_W = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic field_start,
	input wire logic field_parity_flag,
	output logic resize_bypass,
	output logic vert_avg_select,
	output logic horiz_linear,
	output logic in_interlaced,
	output logic out_interlaced,
	output logic field_is_bottom,
	output logic [26:0] row_step,
	output logic [27:0] vert_offset,
	output logic [9:0] avg_init,
	output logic [10:0] target_width,
	output logic [10:0] target_height,
	output logic [10:0] source_width,
	output logic [10:0] source_height,
	output logic [2:0] nlin_init_upper,
	output logic [2:0] lin_inc_upper,
	output logic [2:0] nlin_inc_upper,
	output logic [10:0] right_strip
);

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	logic [31:0] mode_q;
	logic [31:0] row_step_q;
	logic [31:0] voff_top_q;
	logic [31:0] voff_bot_q;
	logic [31:0] target_q;
	logic [31:0] source_q;
	logic [31:0] avg_init_q;
	logic [31:0] strip_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [CNT_W-1:0] field_cnt_q;
	prs_pkg::prs_field_kind_t kind_q;
	prs_pkg::prs_field_kind_t kind_d;

	function automatic logic [31:0] masked(input logic [31:0] v, input logic [31:0] m);
		masked = v & m;
	endfunction : masked

	// Reserved bits are never stored, so they read as zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= `PRS_RESET_VAL;
			row_step_q <= `PRS_RESET_VAL;
			voff_top_q <= `PRS_RESET_VAL;
			voff_bot_q <= `PRS_RESET_VAL;
			target_q <= `PRS_RESET_VAL;
			source_q <= `PRS_RESET_VAL;
			avg_init_q <= `PRS_RESET_VAL;
			strip_q <= `PRS_RESET_VAL;
		end else if (reg_wr) begin
			if (reg_addr == `PRS_OFF_MODE) begin
				mode_q <= masked(reg_wdata, `PRS_MASK_MODE);
			end else if (reg_addr == `PRS_OFF_ROW_STEP) begin
				row_step_q <= masked(reg_wdata, `PRS_MASK_ROW_STEP);
			end else if (reg_addr == `PRS_OFF_VOFF_TOP) begin
				voff_top_q <= masked(reg_wdata, `PRS_MASK_VOFF);
			end else if (reg_addr == `PRS_OFF_VOFF_BOT) begin
				voff_bot_q <= masked(reg_wdata, `PRS_MASK_VOFF);
			end else if (reg_addr == `PRS_OFF_TARGET) begin
				target_q <= masked(reg_wdata, `PRS_MASK_TARGET);
			end else if (reg_addr == `PRS_OFF_SOURCE) begin
				source_q <= masked(reg_wdata, `PRS_MASK_SOURCE);
			end else if (reg_addr == `PRS_OFF_AVG_INIT) begin
				avg_init_q <= masked(reg_wdata, `PRS_MASK_AVG_INIT);
			end else if (reg_addr == `PRS_OFF_STRIP) begin
				strip_q <= masked(reg_wdata, `PRS_MASK_STRIP);
			end
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always_comb begin
		rdata_d = 32'h00000000;
		if (reg_addr == `PRS_OFF_MODE) begin
			rdata_d = mode_q;
		end else if (reg_addr == `PRS_OFF_ROW_STEP) begin
			rdata_d = row_step_q;
		end else if (reg_addr == `PRS_OFF_VOFF_TOP) begin
			rdata_d = voff_top_q;
		end else if (reg_addr == `PRS_OFF_VOFF_BOT) begin
			rdata_d = voff_bot_q;
		end else if (reg_addr == `PRS_OFF_TARGET) begin
			rdata_d = target_q;
		end else if (reg_addr == `PRS_OFF_SOURCE) begin
			rdata_d = source_q;
		end else if (reg_addr == `PRS_OFF_AVG_INIT) begin
			rdata_d = avg_init_q;
		end else if (reg_addr == `PRS_OFF_STRIP) begin
			rdata_d = strip_q;
		end else if (reg_addr == `PRS_OFF_STATUS) begin
			rdata_d = {16'h0000, 8'(field_cnt_q), 5'h00, field_is_bottom, 2'(kind_q)};
		end
	end

	// Data stands only in the cycle after the strobe; zero otherwise
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= 32'h00000000;
		end else if (reg_rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= 32'h00000000;
		end
	end

	assign reg_rdata = rdata_q;

	// ------------------------------------------------------------
	// Field classification
	// ------------------------------------------------------------
	logic mode_in_il;
	logic mode_out_il;
	logic mode_vert_il;
	logic bottom_d;

	assign mode_in_il = mode_q[`PRS_BIT_IN_ILACE];
	assign mode_out_il = mode_q[`PRS_BIT_OUT_ILACE];
	// Vertical path works on fields whenever either side is interlaced
	assign mode_vert_il = mode_in_il | mode_out_il;
	// The flag is trusted as given; software owns the invert setting
	assign bottom_d = mode_q[`PRS_BIT_INVERT] ? field_parity_flag : !field_parity_flag;

	always_comb begin
		if (!mode_vert_il) begin
			kind_d = prs_pkg::PRS_FIELD_FRAME;
		end else if (bottom_d) begin
			kind_d = prs_pkg::PRS_FIELD_BOTTOM;
		end else begin
			kind_d = prs_pkg::PRS_FIELD_TOP;
		end
	end

	// ------------------------------------------------------------
	// Settings applied per field
	// ------------------------------------------------------------
	// Settings are captured only at field start so a mid-field write cannot tear a picture
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			kind_q <= prs_pkg::PRS_FIELD_FRAME;
			field_is_bottom <= 1'b0;
			field_cnt_q <= '0;
		end else if (field_start) begin
			kind_q <= kind_d;
			field_is_bottom <= bottom_d;
			field_cnt_q <= field_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			vert_offset <= 28'h0000000;
		end else if (field_start) begin
			case (kind_d)
				prs_pkg::PRS_FIELD_BOTTOM: vert_offset <= voff_bot_q[27:0];
				default: vert_offset <= voff_top_q[27:0];
			endcase
		end
	end

	// Bottom init only applies to interlaced input; polyphase mode gets zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			avg_init <= 10'h000;
		end else if (field_start) begin
			if (!mode_q[`PRS_BIT_AVG_SEL]) begin
				avg_init <= 10'h000;
			end else if (mode_in_il && bottom_d) begin
				avg_init <= avg_init_q[`PRS_INIT_BOT_MSB:`PRS_INIT_BOT_LSB];
			end else begin
				avg_init <= avg_init_q[`PRS_INIT_TOP_MSB:`PRS_INIT_TOP_LSB];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			resize_bypass <= 1'b0;
			vert_avg_select <= 1'b0;
			horiz_linear <= 1'b0;
			in_interlaced <= 1'b0;
			out_interlaced <= 1'b0;
			row_step <= 27'h0000000;
		end else if (field_start) begin
			resize_bypass <= mode_q[`PRS_BIT_BYPASS];
			vert_avg_select <= mode_q[`PRS_BIT_AVG_SEL];
			horiz_linear <= mode_q[`PRS_BIT_LINEAR];
			in_interlaced <= mode_in_il;
			out_interlaced <= mode_out_il;
			row_step <= row_step_q[26:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			target_width <= 11'h000;
			target_height <= 11'h000;
			source_width <= 11'h000;
			source_height <= 11'h000;
			nlin_init_upper <= 3'h0;
			lin_inc_upper <= 3'h0;
			nlin_inc_upper <= 3'h0;
		end else if (field_start) begin
			target_width <= target_q[`PRS_W_MSB:`PRS_W_LSB];
			target_height <= target_q[`PRS_H_MSB:`PRS_H_LSB];
			source_width <= source_q[`PRS_W_MSB:`PRS_W_LSB];
			source_height <= source_q[`PRS_H_MSB:`PRS_H_LSB];
			nlin_init_upper <= target_q[`PRS_UPPER_A_MSB:`PRS_UPPER_A_LSB];
			lin_inc_upper <= target_q[`PRS_UPPER_B_MSB:`PRS_UPPER_B_LSB];
			nlin_inc_upper <= source_q[`PRS_UPPER_B_MSB:`PRS_UPPER_B_LSB];
		end
	end

	// Linear mode has no strip; zero keeps the horizontal path fully linear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			right_strip <= 11'h000;
		end else if (field_start) begin
			right_strip <= mode_q[`PRS_BIT_LINEAR] ? 11'h000 : strip_q[`PRS_W_MSB:`PRS_W_LSB];
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence seq_field_taken;
		field_start ##1 1'b1;
	endsequence

	sequence seq_mode_read;
		reg_rd && !reg_wr && (reg_addr == `PRS_OFF_MODE);
	endsequence

	chk_avg_select: assert property (seq_field_taken |->
		vert_avg_select == $past(mode_q[`PRS_BIT_AVG_SEL]))
		else $error("avg select not taken from mode");

	chk_parity_decode: assert property (seq_field_taken |->
		field_is_bottom == ($past(mode_q[`PRS_BIT_INVERT]) ? $past(field_parity_flag)
			: !$past(field_parity_flag)))
		else $error("field parity decoded wrongly");

	chk_bypass_follow: assert property (seq_field_taken |->
		resize_bypass == $past(mode_q[`PRS_BIT_BYPASS]))
		else $error("bypass not applied");

	chk_offset_top: assert property (seq_field_taken |->
		(kind_q != prs_pkg::PRS_FIELD_BOTTOM) -> (vert_offset == $past(voff_top_q[27:0])))
		else $error("top offset not applied");

	chk_offset_bottom: assert property (seq_field_taken |->
		(kind_q == prs_pkg::PRS_FIELD_BOTTOM) -> (vert_offset == $past(voff_bot_q[27:0])))
		else $error("bottom offset not applied");

	chk_avg_init_bot: assert property ((field_start && mode_q[`PRS_BIT_AVG_SEL]
		&& mode_in_il && bottom_d) |=> avg_init == $past(avg_init_q[19:10]))
		else $error("bottom average init wrong");

	chk_avg_init_top: assert property ((field_start && mode_q[`PRS_BIT_AVG_SEL]
		&& !(mode_in_il && bottom_d)) |=> avg_init == $past(avg_init_q[9:0]))
		else $error("top average init wrong");

	chk_strip_linear: assert property ((field_start && mode_q[`PRS_BIT_LINEAR]) |=>
		right_strip == 11'h000)
		else $error("strip used in linear mode");

	chk_target_size: assert property (seq_field_taken |->
		{target_width, target_height} == {$past(target_q[22:12]), $past(target_q[10:0])})
		else $error("target size wrong");

	chk_reserved_zero: assert property (seq_mode_read |=>
		(reg_rdata & ~`PRS_MASK_MODE) == 32'h00000000)
		else $error("reserved mode bits read nonzero");

	// ------------------------------------------------------------
	// Checks on shadowed settings and the register port
	// ------------------------------------------------------------
	// Settings must hold between launches, or a picture would change mid-field
	sequence seq_no_field;
		!field_start ##1 1'b1;
	endsequence

	chk_config_hold: assert property (seq_no_field |->
		$stable({resize_bypass, vert_avg_select, horiz_linear, vert_offset, avg_init, row_step}))
		else $error("settings changed without a field start");

	chk_linear_mode: assert property (seq_field_taken |->
		horiz_linear == $past(mode_q[`PRS_BIT_LINEAR]))
		else $error("linear mode not taken from mode");

	chk_out_format: assert property (seq_field_taken |->
		out_interlaced == $past(mode_q[`PRS_BIT_OUT_ILACE]))
		else $error("output format not taken from mode");

	chk_in_format: assert property (seq_field_taken |->
		in_interlaced == $past(mode_q[`PRS_BIT_IN_ILACE]))
		else $error("input format not taken from mode");

	chk_row_step: assert property (seq_field_taken |->
		row_step == $past(row_step_q[26:0]))
		else $error("row step not applied");

	chk_source_size: assert property (seq_field_taken |->
		{source_width, source_height} == {$past(source_q[22:12]), $past(source_q[10:0])})
		else $error("source size wrong");

	chk_nlin_init_up: assert property (seq_field_taken |->
		nlin_init_upper == $past(target_q[30:28]))
		else $error("nonlinear init upper bits wrong");

	chk_lin_inc_up: assert property (seq_field_taken |->
		lin_inc_upper == $past(target_q[26:24]))
		else $error("linear increment upper bits wrong");

	chk_nlin_inc_up: assert property (seq_field_taken |->
		nlin_inc_upper == $past(source_q[26:24]))
		else $error("nonlinear increment upper bits wrong");

	chk_strip_used: assert property ((field_start && !mode_q[`PRS_BIT_LINEAR]) |=>
		right_strip == $past(strip_q[22:12]))
		else $error("strip not applied in anamorphic mode");

	chk_poly_init: assert property ((field_start && !mode_q[`PRS_BIT_AVG_SEL]) |=>
		avg_init == 10'h000)
		else $error("average init used with polyphase filter");

	chk_offset_frame: assert property ((field_start && !mode_vert_il) |=>
		vert_offset == $past(voff_top_q[27:0]))
		else $error("bottom offset used on a progressive frame");

	chk_kind_frame: assert property ((field_start && !mode_vert_il) |=>
		kind_q == prs_pkg::PRS_FIELD_FRAME)
		else $error("progressive frame classed as a field");

	chk_read_idle: assert property (!reg_rd |=>
		reg_rdata == 32'h00000000)
		else $error("read data stands outside the read cycle");

	chk_read_strip: assert property ((reg_rd && (reg_addr == `PRS_OFF_STRIP)) |=>
		reg_rdata == $past(strip_q))
		else $error("strip read data wrong");

	chk_init_write: assert property ((reg_wr && (reg_addr == `PRS_OFF_AVG_INIT)) |=>
		avg_init_q == ($past(reg_wdata) & `PRS_MASK_AVG_INIT))
		else $error("average init write not masked");

endmodule : prs_resizer_config
`default_nettype wire

// ===== test/prs_mover_model.sv
// Behavioural model of the upstream mover that launches frames and fields
`timescale 1ns/1ns
`default_nettype none

module prs_mover_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic send,
	input wire logic flag,
	output logic field_start,
	output logic field_parity_flag
);
	// ----------------------------------------
	// Field launch
	// ----------------------------------------
	// Between launches the flag toggles, so a design that samples it late sees garbage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			field_start <= 1'b0;
			field_parity_flag <= 1'b0;
		end else if (send) begin
			field_start <= 1'b1;
			field_parity_flag <= flag;
		end else begin
			field_start <= 1'b0;
			field_parity_flag <= ~field_parity_flag;
		end
	end
endmodule : prs_mover_model

`default_nettype wire

// ===== test/video_resizer_config_test.sv
// Self-checking bench for the picture resizer configuration block
`timescale 1ns/1ns
`default_nettype none
`include "prs_params.svh"

module video_resizer_config_test;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk, rst_b, reg_wr, reg_rd, send, flag, field_start, field_parity_flag;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic resize_bypass, vert_avg_select, horiz_linear, in_interlaced, out_interlaced;
	logic field_is_bottom;
	logic [26:0] row_step;
	logic [27:0] vert_offset;
	logic [9:0] avg_init;
	logic [10:0] target_width, target_height, source_width, source_height, right_strip;
	logic [2:0] nlin_init_upper, lin_inc_upper, nlin_inc_upper;
	logic [10:0] m;
	int err_total, check_count, cycles;

	typedef struct packed {
		logic [10:0] mode;
		logic flag;
		logic bot;
		logic [27:0] off;
		logic [9:0] init;
		logic [10:0] strip;
	} prs_tb_row_t;
	localparam logic [27:0] OT = 28'h0ABCDEF;
	localparam logic [27:0] OB = 28'h1234567;
	localparam logic [9:0] IT = 10'h123;
	localparam logic [9:0] IB = 10'h2AC;
	localparam int SRC_H = 32'h343;
	localparam int TAR_H = 32'h521;
	// Rounded ratio of field heights, as software would load it
	localparam logic [26:0] STEP = 27'((SRC_H * 65536 + TAR_H / 2) / TAR_H);
	localparam prs_tb_row_t ROWS [8] = '{
		'{11'h008, 1'b1, 1'b1, OT, 10'h000, 11'h7FF},
		'{11'h009, 1'b1, 1'b1, OB, 10'h000, 11'h7FF},
		'{11'h001, 1'b1, 1'b0, OT, 10'h000, 11'h7FF},
		'{11'h000, 1'b0, 1'b1, OT, 10'h000, 11'h7FF},
		'{11'h418, 1'b1, 1'b1, OB, IB, 11'h7FF},
		'{11'h019, 1'b1, 1'b1, OB, IT, 11'h7FF},
		'{11'h41C, 1'b0, 1'b0, OT, IT, 11'h7FF},
		'{11'h40A, 1'b0, 1'b0, OT, 10'h000, 11'h000}
	};

	prs_resizer_config uut (.*);
	prs_mover_model mover (.*);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", exp, reg_rdata);
	endtask : rd

	task automatic field(input logic f);
		@(posedge clk);
		send <= 1'b1;
		flag <= f;
		@(posedge clk);
		send <= 1'b0;
		@(posedge clk);
		#1;
	endtask : field

	task automatic end_of_test;
		if (err_total == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	// Generous ceiling; the sequence needs about a hundred cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_total++;
			end_of_test();
		end
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		{rst_b, reg_wr, reg_rd, send, flag, reg_addr, reg_wdata} = '0;
		{err_total, check_count, cycles} = '0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk("reset_step", 32'h0, 32'(row_step));
		wr(`PRS_OFF_MODE, 32'hFFFFFFFF);
		rd(`PRS_OFF_MODE, 32'h0000041F);
		wr(`PRS_OFF_ROW_STEP, 32'hF8000000 | 32'(STEP));
		wr(`PRS_OFF_VOFF_TOP, {4'hF, OT});
		wr(`PRS_OFF_VOFF_BOT, {4'hF, OB});
		wr(`PRS_OFF_TARGET, 32'h9A5C3D21);
		wr(`PRS_OFF_SOURCE, 32'hFD7A6B43);
		wr(`PRS_OFF_AVG_INIT, 32'hFFFAB123);
		wr(`PRS_OFF_STRIP, 32'hFFFFFFFF);
		wr(8'h3C, 32'hFFFFFFFF);
		rd(`PRS_OFF_ROW_STEP, {5'h00, STEP});
		rd(`PRS_OFF_VOFF_BOT, {4'h0, OB});
		rd(`PRS_OFF_TARGET, 32'h125C3521);
		rd(`PRS_OFF_SOURCE, 32'h057A6343);
		rd(`PRS_OFF_AVG_INIT, 32'h000AB123);
		rd(`PRS_OFF_STRIP, 32'h007FF000);
		rd(8'h3C, 32'h0);
		foreach (ROWS[i]) begin
			wr(`PRS_OFF_MODE, 32'(ROWS[i].mode));
			field(ROWS[i].flag);
			m = ROWS[i].mode;
			chk("mode_out", 32'({m[2], m[4], m[1], m[10], m[0]}),
				32'({resize_bypass, vert_avg_select, horiz_linear, in_interlaced,
				out_interlaced}));
			chk("bottom", 32'(ROWS[i].bot), 32'(field_is_bottom));
			chk("offset", 32'(ROWS[i].off), 32'(vert_offset));
			chk("avg_init", 32'(ROWS[i].init), 32'(avg_init));
			chk("strip", 32'(ROWS[i].strip), 32'(right_strip));
		end
		chk("row_step", 32'(STEP), 32'(row_step));
		chk("target", 32'h5C3521, 32'({target_width, 1'b0, target_height}));
		chk("source", 32'h7A6343, 32'({source_width, 1'b0, source_height}));
		chk("tar_upper", 32'h0A, 32'({nlin_init_upper, lin_inc_upper}));
		chk("src_upper", 32'h5, 32'(nlin_inc_upper));
		// Eight launches so far; the last one was a top field of interlaced input
		rd(`PRS_OFF_STATUS, 32'h00000801);
		// A write landing on the launch edge must wait for the following field
		@(posedge clk);
		send <= 1'b1;
		flag <= 1'b0;
		wr(`PRS_OFF_MODE, 32'h0000000C);
		send <= 1'b0;
		#1;
		chk("late_bypass", 32'h0, 32'(resize_bypass));
		@(posedge clk);
		#1;
		chk("new_bypass", 32'h1, 32'(resize_bypass));
		@(posedge clk);
		rst_b <= 1'b0;
		@(posedge clk);
		#1;
		chk("rst_bypass", 32'h0, 32'(resize_bypass));
		rst_b <= 1'b1;
		rd(`PRS_OFF_VOFF_TOP, 32'h0);
		rd(`PRS_OFF_STATUS, 32'h0);
		end_of_test();
	end
endmodule : video_resizer_config_test

`default_nettype wire
